/* inc/lp_seq_pkg.sv */
package lp_seq_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int REF_CLK_HZ = 25000000;
  // Quality check window length in minimum-frequency VCO cycles.
  localparam int CHECK_WINDOW_CYCLES = 50000;
  // Rising oscillator edges within a window that mark the clock good.
  localparam int OSC_OK_EDGES = 4096;
  localparam int WIN_W = 16;
  localparam int EDGE_W = 13;
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(CHECK_WINDOW_CYCLES - 1);
  localparam logic [EDGE_W-1:0] EDGE_TARGET = EDGE_W'(OSC_OK_EDGES);

  // ----------------------------------------------------------------------
  // Reset and vector codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_NORMAL = 2'h1;
  localparam logic [1:0] VEC_MONITOR = 2'h2;
  localparam logic [1:0] VEC_WATCHDOG = 2'h3;

  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along entry; the exit to ST_RUN changes all three bits
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SWITCH = 3'h1,
    ST_PLL_OFF = 3'h3,
    ST_CORE_OFF = 3'h2,
    ST_SYS_OFF = 3'h6,
    ST_LOWPOWER = 3'h7
  } seq_state_t;

endpackage

/* logic/clock_quality_checker.sv */
`timescale 1ns/10ps
module clock_quality_checker
  import lp_seq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic startCheck,
  input wire logic abortCheck,
  input wire logic freezeCheck,
  // Timing inputs, one-cycle enables
  input wire logic vcoTick,
  input wire logic oscRise,
  // Status
  output logic checkBusy,
  output logic oscOk
);

  logic [WIN_W-1:0] winCount_ff;
  logic [EDGE_W-1:0] edgeCount_ff;
  logic busy_ff;
  logic ok_ff;
  logic [EDGE_W-1:0] nxt_edgeCount;
  logic edgeHit;
  logic winEnd;
  logic runStep;

  assign runStep = busy_ff && !freezeCheck;
  assign nxt_edgeCount = edgeCount_ff + EDGE_W'(1);
  assign edgeHit = runStep && oscRise && (nxt_edgeCount == EDGE_TARGET);
  assign winEnd = runStep && vcoTick && (winCount_ff == WIN_LAST);

  always_ff @(posedge ref_clk) begin
    if (!reset_n || abortCheck) begin
      busy_ff <= 1'b0;
      winCount_ff <= '0;
      edgeCount_ff <= '0;
    end else if (startCheck && !busy_ff) begin
      busy_ff <= 1'b1;
      winCount_ff <= '0;
      edgeCount_ff <= '0;
    end else if (edgeHit) begin
      busy_ff <= 1'b0;
    end else if (winEnd) begin
      // A failed window restarts at once; repeats go on until success or abortCheck.
      winCount_ff <= '0;
      edgeCount_ff <= '0;
    end else if (runStep) begin
      if (vcoTick) begin
        winCount_ff <= winCount_ff + WIN_W'(1);
      end
      if (oscRise) begin
        edgeCount_ff <= nxt_edgeCount;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ok_ff <= 1'b0;
    end else begin
      ok_ff <= edgeHit;
    end
  end

  assign checkBusy = busy_ff;
  assign oscOk = ok_ff;

endmodule // clock_quality_checker

/* logic/low_power_wait_stop_clock_sequencer.sv */
`timescale 1ns/10ps
module low_power_wait_stop_clock_sequencer
  import lp_seq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Core requests and wake sources
  input wire logic waitRequest,
  input wire logic stopRequest,
  input wire logic wakeInterrupt,
  input wire logic watchdogReset,
  // Configuration bits
  input wire logic clock_monitor_enable,
  input wire logic self_clock_mode_enable,
  input wire logic self_clock_irq_enable,
  input wire logic pll_stop_in_wait,
  input wire logic core_stop_in_wait,
  input wire logic system_stop_in_wait,
  input wire logic pseudo_stop_select,
  input wire logic watchdog_run_in_pseudo_stop,
  input wire logic timer_run_in_pseudo_stop,
  // Software control of the PLL select bit and the self-clock flag clear
  input wire logic pllSelectSet,
  input wire logic irqFlagClear,
  // Oscillator status pins
  input wire logic monitorFailPin,
  input wire logic oscRisePin,
  input wire logic vcoTickPin,
  // Clock and power controls
  output logic pll_clock_select,
  output logic pllEnable,
  output logic oscEnable,
  output logic coreClockEnable,
  output logic systemClockEnable,
  output logic timerClockEnable,
  output logic watchdogClockEnable,
  output logic regulatorLowPower,
  output logic counterFreeze,
  // Status
  output logic self_clock_mode,
  output logic self_clock_irq_flag,
  output logic selfClockIrq,
  output logic lowPowerActive,
  output logic stopActive,
  output logic wakeDone,
  output logic monitor_fail_reset,
  output logic [1:0] resetVector
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Oscillator edges arrive as a level from another domain; the rising
  // edge is taken after two flops, so the input must be well below half
  // the reference rate.
  logic [1:0] failSync_ff;
  logic [1:0] oscSync_ff;
  logic [1:0] vcoSync_ff;
  logic oscLast_ff;
  logic vcoLast_ff;
  logic monitorFail;
  logic oscRise;
  logic vcoTick;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      failSync_ff <= 2'h0;
      oscSync_ff <= 2'h0;
      vcoSync_ff <= 2'h0;
      oscLast_ff <= 1'b0;
      vcoLast_ff <= 1'b0;
    end else begin
      failSync_ff <= {failSync_ff[0], monitorFailPin};
      oscSync_ff <= {oscSync_ff[0], oscRisePin};
      vcoSync_ff <= {vcoSync_ff[0], vcoTickPin};
      oscLast_ff <= oscSync_ff[1];
      vcoLast_ff <= vcoSync_ff[1];
    end
  end

  assign monitorFail = failSync_ff[1] && clock_monitor_enable;
  assign oscRise = oscSync_ff[1] && !oscLast_ff;
  assign vcoTick = vcoSync_ff[1] && !vcoLast_ff;

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic isStop_ff;
  logic pll_clock_select_ff;
  logic scm_ff;
  logic flag_ff;
  logic monitor_fail_reset_ff;
  logic wake_ff;
  logic [1:0] vector_ff;
  logic checkBusy;
  logic oscOk;
  logic inLow;
  logic pseudoStop;
  logic fullStop;
  logic failSeen;
  logic scmEntry;
  logic cmFail;
  logic irqWake;
  logic wakeEvent;
  logic resetWake;
  logic startCheck;
  logic abortCheck;
  logic checkNeedsPll;

  assign inLow = (state_ff == ST_LOWPOWER);
  assign pseudoStop = inLow && isStop_ff && pseudo_stop_select;
  assign fullStop = inLow && isStop_ff && !pseudo_stop_select;
  // Full stop has no oscillator, so the monitor is ignored there.
  assign failSeen = monitorFail && !fullStop;
  assign cmFail = failSeen && !self_clock_mode_enable;
  assign scmEntry = failSeen && self_clock_mode_enable && !scm_ff;
  assign irqWake = flag_ff && self_clock_irq_enable;
  assign resetWake = watchdogReset || cmFail;
  assign wakeEvent = inLow && (wakeInterrupt || irqWake || resetWake);
  assign abortCheck = fullStop && scm_ff;
  assign startCheck = scmEntry
    || (scm_ff && !checkBusy && !fullStop && !oscOk);
  assign checkNeedsPll = checkBusy || scmEntry;

  // ----------------------------------------------------------------------
  // Entry and exit sequence
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (waitRequest || stopRequest) begin
          nxt_state = ST_SWITCH;
        end
      end
      ST_SWITCH: nxt_state = ST_PLL_OFF;
      ST_PLL_OFF: nxt_state = ST_CORE_OFF;
      ST_CORE_OFF: nxt_state = ST_SYS_OFF;
      ST_SYS_OFF: nxt_state = ST_LOWPOWER;
      ST_LOWPOWER: begin
        if (wakeEvent) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= ST_RUN;
      isStop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_RUN && stopRequest) begin
        isStop_ff <= 1'b1;
      end else if (state_ff == ST_RUN && waitRequest) begin
        isStop_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // PLL select, self-clock mode and flag
  // ----------------------------------------------------------------------
  logic pllDown;
  assign pllDown = isStop_ff || pll_stop_in_wait;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pll_clock_select_ff <= 1'b0;
    end else if (state_ff == ST_SWITCH && pllDown) begin
      pll_clock_select_ff <= 1'b0;
    end else if (scmEntry) begin
      pll_clock_select_ff <= 1'b0;
    end else if (pllSelectSet && state_ff == ST_RUN && !scm_ff) begin
      pll_clock_select_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scm_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      if (scmEntry) begin
        scm_ff <= 1'b1;
      end else if (oscOk) begin
        scm_ff <= 1'b0;
      end
      // flag sets; set wins over clear
      if (scmEntry) begin
        flag_ff <= 1'b1;
      end else if (irqFlagClear) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reset and wake reporting
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      monitor_fail_reset_ff <= 1'b0;
      wake_ff <= 1'b0;
      vector_ff <= VEC_NORMAL;
    end else begin
      monitor_fail_reset_ff <= cmFail;
      wake_ff <= wakeEvent;
      if (cmFail) begin
        vector_ff <= VEC_MONITOR;
      end else if (watchdogReset) begin
        vector_ff <= VEC_WATCHDOG;
      end else if (wakeEvent) begin
        vector_ff <= VEC_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock quality checker
  // ----------------------------------------------------------------------
  // checks repeat in self-clock mode, but not in full stop
  clock_quality_checker qualityCheck (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .startCheck(startCheck),
    .abortCheck(abortCheck),
    .freezeCheck(1'b0),
    .vcoTick(vcoTick),
    .oscRise(oscRise),
    .checkBusy(checkBusy),
    .oscOk(oscOk)
  );

  // ----------------------------------------------------------------------
  // Clock and power outputs
  // ----------------------------------------------------------------------
  logic pllGate;
  logic coreGate;
  logic sysGate;
  logic deep;

  assign deep = (state_ff == ST_CORE_OFF) || (state_ff == ST_SYS_OFF)
    || inLow;
  assign pllGate = (state_ff != ST_RUN) && (state_ff != ST_SWITCH)
    && pllDown && !pll_clock_select_ff;
  assign coreGate = deep
    && (isStop_ff || core_stop_in_wait || system_stop_in_wait);
  assign sysGate = ((state_ff == ST_SYS_OFF) || inLow)
    && (isStop_ff || system_stop_in_wait);

  assign pllEnable = !pllGate || checkNeedsPll || scm_ff;
  assign oscEnable = !fullStop;
  assign coreClockEnable = !coreGate;
  assign systemClockEnable = !sysGate;
  assign timerClockEnable = !(isStop_ff && inLow)
    || (pseudoStop && timer_run_in_pseudo_stop);
  assign watchdogClockEnable = !(isStop_ff && inLow)
    || (pseudoStop && watchdog_run_in_pseudo_stop);
  assign regulatorLowPower = isStop_ff && inLow && !checkNeedsPll
    && !scm_ff;
  assign counterFreeze = isStop_ff && inLow;

  assign pll_clock_select = pll_clock_select_ff;
  assign self_clock_mode = scm_ff;
  assign self_clock_irq_flag = flag_ff;
  assign selfClockIrq = irqWake;
  assign lowPowerActive = inLow;
  assign stopActive = inLow && isStop_ff;
  assign wakeDone = wake_ff;
  assign monitor_fail_reset = monitor_fail_reset_ff;
  assign resetVector = vector_ff;

endmodule // low_power_wait_stop_clock_sequencer

/* tb/core_request_model.sv */
`timescale 1ns/10ps
// ----------
// Core request model
// ----------
module core_request_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic goWait,
  input wire logic goStop,
  // Sequencer side
  input wire logic wakeDone,
  output logic waitRequest,
  output logic stopRequest
);
  logic busy_ff, waitReq_ff, stopReq_ff;
  assign waitRequest = waitReq_ff;
  assign stopRequest = stopReq_ff;
  // single spaced pulses
  // A command while a transition is open is dropped, as a sleeping core
  // cannot issue another sleep instruction.
  always_ff @(posedge ref_clk) begin
    waitReq_ff <= reset_n && goWait && !busy_ff;
    stopReq_ff <= reset_n && goStop && !goWait && !busy_ff;
    if (!reset_n || wakeDone) begin
      busy_ff <= 1'b0;
    end else if (goWait || goStop) begin
      busy_ff <= 1'b1;
    end
  end
endmodule // core_request_model

/* tb/lp_seq_props.sv */
`timescale 1ns/10ps
// ----------
// Port checks
// ----------
module lp_seq_props
  import lp_seq_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Inputs
  input wire logic waitRequest,
  input wire logic stopRequest,
  input wire logic wakeInterrupt,
  input wire logic clock_monitor_enable,
  input wire logic self_clock_mode_enable,
  input wire logic self_clock_irq_enable,
  input wire logic monitorFailPin,
  input wire logic pll_stop_in_wait,
  input wire logic core_stop_in_wait,
  input wire logic system_stop_in_wait,
  input wire logic pseudo_stop_select,
  input wire logic watchdog_run_in_pseudo_stop,
  input wire logic timer_run_in_pseudo_stop,
  // Outputs
  input wire logic pll_clock_select,
  input wire logic pllEnable,
  input wire logic oscEnable,
  input wire logic coreClockEnable,
  input wire logic systemClockEnable,
  input wire logic timerClockEnable,
  input wire logic watchdogClockEnable,
  input wire logic regulatorLowPower,
  input wire logic counterFreeze,
  input wire logic self_clock_mode,
  input wire logic self_clock_irq_flag,
  input wire logic lowPowerActive,
  input wire logic stopActive,
  input wire logic wakeDone,
  input wire logic monitor_fail_reset,
  input wire logic [1:0] resetVector
);
  wire anyReq = waitRequest | stopRequest;
  wire pllSelf = lowPowerActive && self_clock_mode;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_entry_five_edges: assert property (
    $rose(lowPowerActive) |-> $past(anyReq, 5))
    else $error("low power did not follow request by five edges");
  a_stop_order: assert property (
    stopRequest && !lowPowerActive && !self_clock_mode |=>
    ##1 !pll_clock_select && !pllEnable ##1 !coreClockEnable
    ##1 !systemClockEnable ##1 stopActive)
    else $error("stop entry order broken");
  a_full_stop_off: assert property (
    stopActive && !pseudo_stop_select |-> !oscEnable && counterFreeze)
    else $error("full stop left oscillator or counters running");
  a_pseudo_runs: assert property (
    stopActive && pseudo_stop_select |-> oscEnable
    && timerClockEnable == timer_run_in_pseudo_stop
    && watchdogClockEnable == watchdog_run_in_pseudo_stop)
    else $error("pseudo stop clock gating wrong");
  a_stop_regulator: assert property (
    stopActive && !self_clock_mode |-> regulatorLowPower)
    else $error("regulator not told to save power");
  a_wait_gating: assert property (
    lowPowerActive && !stopActive && !self_clock_mode
    && !(clock_monitor_enable && self_clock_mode_enable && monitorFailPin)
    |->
    pllEnable == !pll_stop_in_wait && !regulatorLowPower
    && coreClockEnable == !(core_stop_in_wait || system_stop_in_wait)
    && systemClockEnable == !system_stop_in_wait)
    else $error("wait gating wrong");
  a_scm_keeps_pll: assert property (
    pllSelf && (!stopActive || pseudo_stop_select) |->
    pllEnable && !regulatorLowPower)
    else $error("self clock low power dropped pll or regulator");
  a_wake_next: assert property (
    lowPowerActive && wakeInterrupt |=> !lowPowerActive && wakeDone)
    else $error("wake interrupt not served next cycle");
  a_flag_wakes: assert property (
    lowPowerActive && self_clock_irq_flag && self_clock_irq_enable
    |-> ##[1:4] wakeDone)
    else $error("self clock flag did not wake");
  a_monitor_off: assert property (
    !clock_monitor_enable |-> !monitor_fail_reset
    && !$rose(self_clock_irq_flag))
    else $error("clock loss acted on with monitor off");
  a_monitor_vector: assert property (
    monitor_fail_reset |-> ##[0:1] resetVector == VEC_MONITOR)
    else $error("monitor reset vector wrong");

  c_pseudo_stop: cover property (stopActive && pseudo_stop_select);
  c_scm_wait: cover property (pllSelf);
  c_monitor_reset: cover property (monitor_fail_reset);
endmodule // lp_seq_props

bind low_power_wait_stop_clock_sequencer lp_seq_props chk (.*);

/* tb/test_low_power_wait_stop_clock_sequencer.sv */
`timescale 1ns/10ps
module test_low_power_wait_stop_clock_sequencer
  import lp_seq_pkg::*;
;
  // ----------
  // Signals
  // ----------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic goWait = 1'b0, goStop = 1'b0, wakeInterrupt = 1'b0;
  logic watchdogReset = 1'b0, pllSelectSet = 1'b0, irqFlagClear = 1'b0;
  logic monitorFailPin = 1'b0, oscRisePin = 1'b0, vcoTickPin = 1'b0;
  logic oscRun = 1'b1;
  logic [1:0] oscDiv = 2'h0;
  logic [8:0] cfg = 9'h000;
  logic clock_monitor_enable, self_clock_mode_enable, self_clock_irq_enable;
  logic pll_stop_in_wait, core_stop_in_wait, system_stop_in_wait;
  logic pseudo_stop_select, watchdog_run_in_pseudo_stop;
  logic timer_run_in_pseudo_stop, waitRequest, stopRequest;
  logic pll_clock_select, pllEnable, oscEnable, coreClockEnable;
  logic systemClockEnable, timerClockEnable, watchdogClockEnable;
  logic regulatorLowPower, counterFreeze, self_clock_mode;
  logic self_clock_irq_flag, selfClockIrq, lowPowerActive, stopActive;
  logic wakeDone, monitor_fail_reset;
  logic [1:0] resetVector;
  int mismatches = 0;
  int comparisons = 0;
  // Rows: wait bits {pll, core, system}, then pll, core, system, select.
  logic [6:0] rows [8] = '{7'h0F, 7'h19, 7'h2B, 7'h39, 7'h46, 7'h50,
    7'h62, 7'h70};
  assign {clock_monitor_enable, self_clock_mode_enable, self_clock_irq_enable,
    pll_stop_in_wait, core_stop_in_wait, system_stop_in_wait,
    pseudo_stop_select, watchdog_run_in_pseudo_stop,
    timer_run_in_pseudo_stop} = cfg;

  always #20 ref_clk = ~ref_clk;
  // Edges every third cycle keep the two-flop synchronisers exact.
  always @(posedge ref_clk) begin
    oscDiv <= (oscDiv == 2'h2) ? 2'h0 : oscDiv + 2'h1;
    if (oscDiv == 2'h2) begin
      vcoTickPin <= ~vcoTickPin;
      oscRisePin <= oscRun ? ~oscRisePin : oscRisePin;
    end
  end

  core_request_model core (.ref_clk, .reset_n, .goWait, .goStop,
    .wakeDone, .waitRequest, .stopRequest);
  low_power_wait_stop_clock_sequencer dut (.*);

  // ----------
  // Tasks
  // ----------
  task automatic cmpBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpVec(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return lowPowerActive;
      1: return wakeDone;
      2: return monitor_fail_reset;
      3: return self_clock_mode;
      default: return !self_clock_mode;
    endcase
  endfunction

  task automatic waitSig(input int s, input int lim);
    for (int n = 0; sig(s) !== 1'b1; n++) begin
      if (n > lim) begin
        cmpBit(sig(s), 1'b1);
        tally_and_finish();
      end
      @(negedge ref_clk);
    end
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk);
    {goWait, goStop, pllSelectSet, irqFlagClear} <= m;
    @(posedge ref_clk);
    {goWait, goStop, pllSelectSet, irqFlagClear} <= 4'h0;
  endtask

  task automatic enter(input logic [3:0] m, input logic [8:0] c);
    @(posedge ref_clk);
    cfg <= c;
    pulse(m);
    waitSig(0, 20);
  endtask

  task automatic wake();
    @(posedge ref_clk);
    wakeInterrupt <= 1'b1;
    waitSig(1, 10);
    @(posedge ref_clk);
    wakeInterrupt <= 1'b0;
  endtask

  task automatic fail(input logic f);
    @(posedge ref_clk);
    monitorFailPin <= f;
    oscRun <= !f;
  endtask

  task automatic doReset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
  endtask

  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    cmpVec(resetVector, VEC_NORMAL);
    for (int i = 0; i < 8; i++) begin
      pulse(4'h2);
      enter(4'h8, {3'h4, rows[i][6:4], 3'h0});
      cmpBit(pllEnable, rows[i][3]);
      cmpBit(coreClockEnable, rows[i][2]);
      cmpBit(systemClockEnable, rows[i][1]);
      wake();
      cmpBit(pll_clock_select, rows[i][0]);
    end
    for (int k = 0; k < 3; k++) begin
      pulse(4'h2);
      enter(4'h4, {6'h20, k != 0, k == 2, k == 1});
      cmpBit(pll_clock_select, 1'b0);
      cmpBit(oscEnable, k != 0);
      cmpBit(timerClockEnable, k == 1);
      cmpBit(watchdogClockEnable, k == 2);
      wake();
    end
    enter(4'h8, 9'h000);
    fail(1'b1);
    repeat (10) @(negedge ref_clk);
    cmpBit(lowPowerActive, 1'b1);
    cmpBit(self_clock_irq_flag, 1'b0);
    fail(1'b0);
    wake();
    enter(4'h8, 9'h100);
    fail(1'b1);
    waitSig(2, 10);
    cmpBit(lowPowerActive, 1'b0);
    fail(1'b0);
    doReset();
    enter(4'h8, 9'h1A0);
    fail(1'b1);
    waitSig(3, 10);
    repeat (5) @(negedge ref_clk);
    cmpBit(lowPowerActive, 1'b1);
    cmpBit(self_clock_irq_flag, 1'b1);
    fail(1'b0);
    waitSig(4, 30000);
    cmpBit(lowPowerActive, 1'b1);
    cmpBit(pllEnable, 1'b0);
    wake();
    cmpBit(self_clock_mode, 1'b0);
    pulse(4'h1);
    enter(4'h8, 9'h1E0);
    fail(1'b1);
    waitSig(1, 20);
    cmpBit(self_clock_mode, 1'b1);
    @(posedge ref_clk);
    monitorFailPin <= 1'b0;
    pulse(4'h3);
    cmpBit(pll_clock_select, 1'b0);
    enter(4'h8, 9'h1E0);
    cmpBit(pllEnable, 1'b1);
    wake();
    cmpBit(self_clock_mode, 1'b1);
    fail(1'b0);
    waitSig(4, 30000);
    enter(4'h8, 9'h100);
    @(posedge ref_clk);
    watchdogReset <= 1'b1;
    waitSig(1, 10);
    cmpVec(resetVector, VEC_WATCHDOG);
    @(posedge ref_clk);
    watchdogReset <= 1'b0;
    pulse(4'h2);
    enter(4'h8, 9'h100);
    doReset();
    cmpBit(lowPowerActive, 1'b0);
    cmpBit(pll_clock_select, 1'b0);
    cmpVec(resetVector, VEC_NORMAL);
    tally_and_finish();
  end
endmodule // test_low_power_wait_stop_clock_sequencer
